// file: test/sfes_ctrl_bench.sv
`timescale 1ns/100ps
module sfes_ctrl_bench;
  logic                 clk, nrst, sck, cs_n, mosi, array_protected, prot_hit;
  logic [23:0]          rd_addr, prot_addr_reg, erase_addr_reg, prog_addr_reg;
  logic [23:0]          a, blk;
  sfes_pkg::sfes_kind_t prot_kind_reg, erase_kind_reg;
  logic                 pend_prog_reg, write_enable_latch, suspend_flag;
  logic                 ready_busy_flag, rd_undefined_reg, erase_start_reg;
  logic                 prog_start_reg, op_done_reg;
  int                   fails, checks_done, starts, progs, cycles, n;
  logic [7:0]           ops [5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
  logic [7:0]           bo [5] = '{8'h20, 8'h20, 8'h52, 8'h60, 8'h60};
  int                   bn [5] = '{24, 35, 32, 12, 8};

  sfes_host i_host (.sck, .cs_n, .mosi);
  sfes_ctrl #(.BLK4_TIME_US(1), .BLK32_TIME_US(1), .BLK64_TIME_US(60),
    .CHIP_TIME_US(30), .PROG_TIME_US(1)) i_dut (.clk, .nrst, .sck, .cs_n,
    .mosi, .array_protected, .prot_hit, .rd_addr, .prot_addr_reg,
    .prot_kind_reg, .pend_prog_reg, .write_enable_latch, .suspend_flag,
    .ready_busy_flag, .rd_undefined_reg, .erase_start_reg, .erase_addr_reg,
    .erase_kind_reg, .prog_start_reg, .prog_addr_reg, .op_done_reg);

  always #12.5 clk = ~clk;

  // Count start pulses; the ceiling is well above the planned run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (erase_start_reg === 1'b1) starts <= starts + 1;
    if (prog_start_reg === 1'b1) progs <= progs + 1;
    if (cycles == 40000) begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic op(input logic [7:0] c, input logic [23:0] ad, input int b);
    i_host.frame({c, ad, 8'hA5}, b);
    @(negedge clk);
  endtask

  task automatic wt(input int c);
    repeat (c) @(negedge clk);
  endtask

  task automatic idle();
    for (int i = 0; i < 3000 && ready_busy_flag !== 1'b0; i++) @(negedge clk);
    wt(2);
  endtask

  function automatic logic [23:0] base(input logic [7:0] c, logic [23:0] ad);
    case (c)
      8'h20: base = ad & 24'hFFF000;
      8'h52: base = ad & 24'hFF8000;
      8'hD8: base = ad & 24'hFF0000;
      default: base = 24'h000000;
    endcase
  endfunction

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    array_protected = 1'b0;
    prot_hit = 1'b0;
    rd_addr = 24'h000000;
    {fails, checks_done, starts, progs, cycles} = '0;
    void'($urandom(36));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    wt(4);
    // Write disable drops a latch that write enable has just set
    op(8'h06, 24'h000000, 8);
    op(8'h04, 24'h000000, 8);
    chk("latch", 24'h000000, 24'(write_enable_latch));
    // Every erase opcode, then a retry with the latch already clear
    foreach (ops[k]) begin
      a = 24'($urandom);
      n = starts;
      op(8'h06, a, 8);
      chk("latch", 24'h000001, 24'(write_enable_latch));
      op(ops[k], a, 32 + 8 * (k % 2));
      chk("starts", 24'(n + 1), 24'(starts));
      chk("base", base(ops[k], a), erase_addr_reg);
      chk("kind", 24'(k > 3 ? 3 : k), 24'(erase_kind_reg));
      chk("latch", 24'h000000, 24'(write_enable_latch));
      chk("busy", 24'h000001, 24'(ready_busy_flag));
      if (k == 4) begin
        op(8'h75, a, 8);
        wt(830);
        chk("suspend", 24'h000000, 24'(suspend_flag));
      end
      idle();
      op(ops[k], a, 32);
      chk("starts", 24'(n + 1), 24'(starts));
    end
    // Short, misaligned and protected requests abort and clear the latch
    foreach (bo[j]) begin
      @(posedge clk);
      prot_hit <= (j == 2);
      array_protected <= (j == 4);
      op(8'h06, a, 8);
      n = starts;
      a = 24'($urandom);
      op(bo[j], a, bn[j]);
      if (j == 2) begin
        chk("prot base", base(8'h52, a), prot_addr_reg);
        chk("prot kind", 24'h000001, 24'(prot_kind_reg));
        chk("prot prog", 24'h000000, 24'(pend_prog_reg));
      end
      chk("latch", 24'h000000, 24'(write_enable_latch));
      chk("starts", 24'(n), 24'(starts));
    end
    @(posedge clk);
    {prot_hit, array_protected} <= 2'b00;
    // Suspend a long erase, latch clear, then probe the suspended block
    a = 24'($urandom);
    blk = base(8'hD8, a);
    op(8'h06, a, 8);
    op(8'hD8, a, 32);
    n = starts;
    op(8'h75, a, 12);
    wt(830);
    chk("suspend", 24'h000000, 24'(suspend_flag));
    op(8'h75, a, 16);
    wt(800);
    chk("suspend", 24'h000001, 24'(suspend_flag));
    chk("busy", 24'h000000, 24'(ready_busy_flag));
    @(posedge clk);
    rd_addr <= blk | 24'($urandom_range(16'hFFFF));
    wt(3);
    chk("undef", 24'h000001, 24'(rd_undefined_reg));
    @(posedge clk);
    rd_addr <= blk ^ 24'h010000;
    wt(3);
    chk("undef", 24'h000000, 24'(rd_undefined_reg));
    op(8'h06, a, 8);
    op(8'h20, blk, 32);
    chk("latch", 24'h000001, 24'(write_enable_latch));
    op(8'h02, a, 40);
    chk("latch", 24'h000000, 24'(write_enable_latch));
    chk("progs", 24'h000000, 24'(progs));
    op(8'h06, a, 8);
    op(8'h02, blk ^ 24'h010000, 40);
    chk("progs", 24'h000001, 24'(progs));
    chk("page", blk ^ 24'h010000, prog_addr_reg);
    chk("prot prog", 24'h000001, 24'(pend_prog_reg));
    idle();
    chk("suspend", 24'h000001, 24'(suspend_flag));
    op(8'h7A, a, 8);
    chk("suspend", 24'h000000, 24'(suspend_flag));
    chk("busy", 24'h000001, 24'(ready_busy_flag));
    idle();
    op(8'h7A, a, 8);
    chk("busy", 24'h000000, 24'(ready_busy_flag));
    chk("starts", 24'(n), 24'(starts));
    complete_run();
  end
endmodule

// file: test/sfes_ctrl_properties.sv
`timescale 1ns/100ps
module sfes_ctrl_chk (
  input wire logic        clk,                // Core clock
  input wire logic        nrst,               // Reset, active low
  input wire logic        cs_n,               // Chip select
  input wire logic        write_enable_latch, // Latch
  input wire logic        suspend_flag,       // Suspended
  input wire logic        ready_busy_flag,    // Busy
  input wire logic        rd_undefined_reg,   // Read undefined
  input wire logic        erase_start_reg,    // Erase pulse
  input wire logic [23:0] erase_addr_reg,     // Erase base
  input sfes_pkg::sfes_kind_t erase_kind_reg, // Erase size
  input wire logic        prog_start_reg,     // Program pulse
  input wire logic [23:0] prog_addr_reg,      // Page base
  input wire logic        op_done_reg         // Done pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_start_busy: assert property (
    erase_start_reg |-> ready_busy_flag [*8]) else $error("busy short");
  chk_start_wel: assert property (
    (erase_start_reg || prog_start_reg) |-> $past(write_enable_latch))
    else $error("start without latch");
  chk_start_cs: assert property (
    erase_start_reg |-> cs_n && $past(cs_n, 3)) else $error("start in frame");
  chk_erase_mask: assert property (
    erase_start_reg |-> (erase_kind_reg == sfes_pkg::SFES_KIND_4K
      && erase_addr_reg[11:0] == 12'h000)
    || (erase_kind_reg == sfes_pkg::SFES_KIND_32K
      && erase_addr_reg[14:0] == 15'h0000)
    || (erase_kind_reg == sfes_pkg::SFES_KIND_64K
      && erase_addr_reg[15:0] == 16'h0000)
    || erase_addr_reg == 24'h000000) else $error("base not masked");
  chk_done_wel: assert property (
    op_done_reg |-> !write_enable_latch && $past(ready_busy_flag))
    else $error("latch set at done");
  chk_susp_ready: assert property (
    $rose(suspend_flag) |-> !ready_busy_flag) else $error("busy in suspend");
  chk_no_start: assert property (
    erase_start_reg |-> !$past(suspend_flag)) else $error("erase in suspend");
  chk_prog_page: assert property (
    prog_start_reg |-> prog_addr_reg[7:0] == 8'h00 && ready_busy_flag)
    else $error("program start bad");
  chk_undef_susp: assert property (
    rd_undefined_reg |-> suspend_flag || $past(suspend_flag))
    else $error("undefined read without suspend");
  cover property (erase_kind_reg == sfes_pkg::SFES_KIND_CHIP
    && erase_start_reg);
  cover property ($rose(suspend_flag));
  cover property (prog_start_reg && suspend_flag);
endmodule

bind sfes_ctrl sfes_ctrl_chk i_chk (.clk, .nrst, .cs_n, .write_enable_latch,
  .suspend_flag, .ready_busy_flag, .rd_undefined_reg, .erase_start_reg,
  .erase_addr_reg, .erase_kind_reg, .prog_start_reg, .prog_addr_reg,
  .op_done_reg);

// file: test/sfes_host.sv
`timescale 1ns/100ps
module sfes_host (
  output logic sck,  // Serial clock, still between frames
  output logic cs_n, // Chip select, active low
  output logic mosi  // Serial data, MSB first
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic frame(input logic [39:0] bits, input int n);
    #17 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = bits[39 - i];
      #40 sck = 1'b1;
      #40 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    // Released line flips so a stale bit never passes for data
    mosi = ~mosi;
    #600;
  endtask
endmodule

// file: verilog/sfes_ctrl.sv
// Functional notes
// - Opcodes 20h, 52h, D8h pick block size
// - Block erase needs write enable latch set
// - Three address bytes, extra bytes ignored
// - Erase starts when chip select releases
// - Low address bits ignored per size
// - Short or misaligned frame aborts erase
// - Protected block erase refused, back idle
// - Aborted block erase clears write enable
// - Busy reported while erase runs
// - Write enable cleared before erase ends
// - 60h or C7h erase whole array
// - Array erase aborts misaligned, clears latch
// - Protected array refuses whole erase
// - Suspend ignored during whole-array erase
// - Program allowed, not suspendable, in suspend
// - Suspend ignores write enable latch
// - 75h suspends within latency after release
// - Suspend sets flag, shows ready
// - Suspend needs whole byte-aligned opcode
// - Reads of suspended region flagged undefined
// - Conflicting program or erase aborts, clears
// - Disallowed commands in suspend silently ignored
// - Suspend command set restricted
// - Suspend program only outside suspended 64K
// - Resume needs suspend flag and ready
`timescale 1ns/100ps
`include "sfes_regs.svh"

module sfes_ctrl #(
  parameter int unsigned BLK4_TIME_US  = 1000,  // 4K erase time
  parameter int unsigned BLK32_TIME_US = 2000,  // 32K erase time
  parameter int unsigned BLK64_TIME_US = 4000,  // 64K erase time
  parameter int unsigned CHIP_TIME_US  = 50000, // Whole-array erase time
  parameter int unsigned PROG_TIME_US  = 1000   // Page program time
) (
  input  wire logic        clk,                // Core clock, 40 MHz
  input  wire logic        nrst,               // Async reset, active low
  input  wire logic        sck,                // Serial clock
  input  wire logic        cs_n,               // Chip select, active low
  input  wire logic        mosi,               // Serial data in
  input  wire logic        array_protected,    // Any area protected
  input  wire logic        prot_hit,           // Checked region protected
  input  wire logic [23:0] rd_addr,            // Current read address
  output logic [23:0]      prot_addr_reg,      // Region base to check
  output sfes_pkg::sfes_kind_t prot_kind_reg,  // Region size to check
  output logic             pend_prog_reg,      // Check is for a program
  output logic             write_enable_latch, // Write enable latch
  output logic             suspend_flag,       // Operation suspended
  output logic             ready_busy_flag,    // High while busy
  output logic             rd_undefined_reg,   // Read hits suspended area
  output logic             erase_start_reg,    // Erase begins, pulse
  output logic [23:0]      erase_addr_reg,     // Erase region base
  output sfes_pkg::sfes_kind_t erase_kind_reg, // Erase region size
  output logic             prog_start_reg,     // Program begins, pulse
  output logic [23:0]      prog_addr_reg,      // Program page base
  output logic             op_done_reg         // Operation ends, pulse
);

  localparam logic [31:0] BLK4_CYC  = 32'(BLK4_TIME_US * `SFES_CLK_MHZ);
  localparam logic [31:0] BLK32_CYC = 32'(BLK32_TIME_US * `SFES_CLK_MHZ);
  localparam logic [31:0] BLK64_CYC = 32'(BLK64_TIME_US * `SFES_CLK_MHZ);
  localparam logic [31:0] CHIP_CYC  = 32'(CHIP_TIME_US * `SFES_CLK_MHZ);
  localparam logic [31:0] PROG_CYC  = 32'(PROG_TIME_US * `SFES_CLK_MHZ);
  localparam logic [11:0] SUS_WAIT  = 12'(`SFES_SUS_LAT_CYC - 1);

  // Bits ignored inside a region of the given size
  function automatic logic [23:0] sfes_mask_of(sfes_pkg::sfes_kind_t k);
    unique case (k)
      sfes_pkg::SFES_KIND_4K:  sfes_mask_of = `SFES_MASK_4K;
      sfes_pkg::SFES_KIND_32K: sfes_mask_of = `SFES_MASK_32K;
      sfes_pkg::SFES_KIND_64K: sfes_mask_of = `SFES_MASK_64K;
      sfes_pkg::SFES_KIND_CHIP: sfes_mask_of = `SFES_MASK_ALL;
    endcase
  endfunction

  // Two addresses fall in the same region
  function automatic logic sfes_same(logic [23:0] a, logic [23:0] b,
                                     logic [23:0] m);
    sfes_same = (a & ~m) == (b & ~m);
  endfunction

  logic [7:0]  link_op;
  logic [23:0] link_addr;
  logic [2:0]  link_bytes;
  logic [2:0]  link_bits;
  logic        link_tog;

  sfes_link u_link (
    .nrst          (nrst),
    .sck           (sck),
    .cs_n          (cs_n),
    .mosi          (mosi),
    .opcode_reg    (link_op),
    .addr_reg      (link_addr),
    .byte_cnt_reg  (link_bytes),
    .bit_cnt_reg   (link_bits),
    .frame_tog_reg (link_tog)
  );

  logic                 cs_meta_reg;
  logic                 cs_sync_reg;
  logic                 cs_prev_reg;
  logic                 tog_meta_reg;
  logic                 tog_sync_reg;
  logic                 tog_seen_reg;
  logic                 frame_end;
  logic                 aligned;
  logic                 op_ok;
  logic                 addr_ok;
  logic                 prog_ok;
  logic                 is_blk;
  sfes_pkg::sfes_kind_t blk_kind;
  sfes_pkg::sfes_state_t state_reg;
  logic                 wel_reg;
  logic                 ers_run_reg;
  logic                 ers_susp_reg;
  logic [31:0]          ers_cnt_reg;
  logic                 prg_run_reg;
  logic                 prg_susp_reg;
  logic [31:0]          prg_cnt_reg;
  logic                 sus_pend_reg;
  logic                 sus_prg_reg;
  logic [11:0]          sus_wait_reg;
  logic                 busy;
  logic                 sus_any;
  logic                 sus_fire;
  logic                 sus_target_ok;
  logic                 check_go;
  logic                 check_fail;
  logic                 ers_fin;
  logic                 prg_fin;
  logic                 act_wel_set;
  logic                 act_wel_clr;
  logic                 act_check;
  logic                 act_chip;
  logic                 act_sus;
  logic                 act_res;

  // Chip select and frame marker synchronisers; link words are read only
  // after the release is seen, when the serial clock has stopped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cs_meta_reg  <= 1'b1;
      cs_sync_reg  <= 1'b1;
      cs_prev_reg  <= 1'b1;
      tog_meta_reg <= 1'b0;
      tog_sync_reg <= 1'b0;
      tog_seen_reg <= 1'b0;
    end else begin
      cs_meta_reg  <= cs_n;
      cs_sync_reg  <= cs_meta_reg;
      cs_prev_reg  <= cs_sync_reg;
      tog_meta_reg <= link_tog;
      tog_sync_reg <= tog_meta_reg;
      if (cs_sync_reg && !cs_prev_reg) begin
        tog_seen_reg <= tog_sync_reg;
      end
    end
  end

  assign frame_end = cs_sync_reg && !cs_prev_reg &&
                     (tog_sync_reg != tog_seen_reg) && link_bytes != 3'h0;
  assign aligned = link_bits == 3'h0;
  assign op_ok   = aligned && link_bytes >= `SFES_OPCODE_BYTES;
  assign addr_ok = aligned && link_bytes >= `SFES_ADDR_END_BYTES;
  assign prog_ok = aligned && link_bytes >= `SFES_PROG_MIN_BYTES;

  assign busy            = ers_run_reg || prg_run_reg;
  assign sus_any         = ers_susp_reg || prg_susp_reg;
  assign ready_busy_flag = busy;
  assign suspend_flag    = sus_any;
  assign write_enable_latch = wel_reg;

  always_comb begin
    is_blk   = 1'b1;
    blk_kind = sfes_pkg::SFES_KIND_4K;
    unique case (link_op)
      `SFES_OP_ERASE_4K:  blk_kind = sfes_pkg::SFES_KIND_4K;
      `SFES_OP_ERASE_32K: blk_kind = sfes_pkg::SFES_KIND_32K;
      `SFES_OP_ERASE_64K: blk_kind = sfes_pkg::SFES_KIND_64K;
      default:            is_blk   = 1'b0;
    endcase
  end

  assign sus_target_ok = (prg_run_reg && !ers_susp_reg) ||
                         (ers_run_reg && !prg_run_reg &&
                          erase_kind_reg != sfes_pkg::SFES_KIND_CHIP);

  // Command decode at the end of a frame
  always_comb begin
    act_wel_set = 1'b0;
    act_wel_clr = 1'b0;
    act_check   = 1'b0;
    act_chip    = 1'b0;
    act_sus     = 1'b0;
    act_res     = 1'b0;
    if (frame_end) begin
      unique case (link_op)
        `SFES_OP_WREN: act_wel_set = op_ok;
        `SFES_OP_WRDI: act_wel_clr = op_ok;
        `SFES_OP_ERASE_4K, `SFES_OP_ERASE_32K, `SFES_OP_ERASE_64K: begin
          if (prg_susp_reg && addr_ok &&
              sfes_same(link_addr, prog_addr_reg, `SFES_MASK_64K)) begin
            act_wel_clr = 1'b1;
          end else if (!sus_any && !busy && wel_reg) begin
            act_wel_clr = !addr_ok;
            act_check   = addr_ok;
          end
        end
        `SFES_OP_CHIP_A, `SFES_OP_CHIP_B: begin
          if (!sus_any && !busy && wel_reg) begin
            act_wel_clr = !aligned || array_protected;
            act_chip    = aligned && !array_protected;
          end
        end
        `SFES_OP_SUSPEND: begin
          act_sus = op_ok && !sus_pend_reg && sus_target_ok;
        end
        `SFES_OP_RESUME: begin
          act_res = op_ok && sus_any && !busy;
        end
        `SFES_OP_PROGRAM: begin
          if (!prg_susp_reg && !busy && wel_reg) begin
            if (!prog_ok || (ers_susp_reg &&
                sfes_same(link_addr, erase_addr_reg, `SFES_MASK_64K))) begin
              act_wel_clr = 1'b1;
            end else begin
              act_check = 1'b1;
            end
          end
        end
        default: act_wel_clr = 1'b0;
      endcase
    end
  end

  // One-cycle protection lookup before a block erase or program starts
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= sfes_pkg::SFES_ST_IDLE;
      prot_addr_reg <= `SFES_ADDR_RST;
      prot_kind_reg <= sfes_pkg::SFES_KIND_4K;
      pend_prog_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        sfes_pkg::SFES_ST_IDLE: begin
          if (act_check) begin
            state_reg     <= sfes_pkg::SFES_ST_CHECK;
            pend_prog_reg <= !is_blk;
            prot_kind_reg <= blk_kind;
            prot_addr_reg <= is_blk ? (link_addr & ~sfes_mask_of(blk_kind))
                                    : (link_addr & ~`SFES_MASK_PAGE);
          end
        end
        sfes_pkg::SFES_ST_CHECK: state_reg <= sfes_pkg::SFES_ST_IDLE;
      endcase
    end
  end

  assign check_go   = state_reg == sfes_pkg::SFES_ST_CHECK && !prot_hit;
  assign check_fail = state_reg == sfes_pkg::SFES_ST_CHECK && prot_hit;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wel_reg <= `SFES_WEL_RST;
    end else if (act_wel_set) begin
      wel_reg <= 1'b1;
    end else if (act_wel_clr || check_fail || check_go || act_chip) begin
      wel_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sus_pend_reg <= 1'b0;
      sus_prg_reg  <= 1'b0;
      sus_wait_reg <= 12'h000;
    end else if (act_sus) begin
      sus_pend_reg <= 1'b1;
      sus_prg_reg  <= prg_run_reg;
      sus_wait_reg <= SUS_WAIT;
    end else if (sus_pend_reg) begin
      if (sus_wait_reg == 12'h000) begin
        sus_pend_reg <= 1'b0;
      end else begin
        sus_wait_reg <= sus_wait_reg - 12'h001;
      end
    end
  end

  assign sus_fire = sus_pend_reg && sus_wait_reg == 12'h000;
  assign ers_fin  = ers_run_reg && ers_cnt_reg == 32'h0000_0001 &&
                    !(sus_fire && !sus_prg_reg);
  assign prg_fin  = prg_run_reg && prg_cnt_reg == 32'h0000_0001 &&
                    !(sus_fire && sus_prg_reg);

  // Erase engine; the count is held while suspended so a resume picks
  // up where it stopped rather than starting the region over
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ers_run_reg    <= 1'b0;
      ers_susp_reg   <= 1'b0;
      ers_cnt_reg    <= 32'h0000_0000;
      erase_addr_reg <= `SFES_ADDR_RST;
      erase_kind_reg <= sfes_pkg::SFES_KIND_4K;
    end else if (check_go && !pend_prog_reg) begin
      ers_run_reg    <= 1'b1;
      erase_addr_reg <= prot_addr_reg;
      erase_kind_reg <= prot_kind_reg;
      unique case (prot_kind_reg)
        sfes_pkg::SFES_KIND_4K:   ers_cnt_reg <= BLK4_CYC;
        sfes_pkg::SFES_KIND_32K:  ers_cnt_reg <= BLK32_CYC;
        sfes_pkg::SFES_KIND_64K:  ers_cnt_reg <= BLK64_CYC;
        sfes_pkg::SFES_KIND_CHIP: ers_cnt_reg <= CHIP_CYC;
      endcase
    end else if (act_chip) begin
      ers_run_reg    <= 1'b1;
      ers_cnt_reg    <= CHIP_CYC;
      erase_addr_reg <= `SFES_ADDR_RST;
      erase_kind_reg <= sfes_pkg::SFES_KIND_CHIP;
    end else if (act_res && !prg_susp_reg) begin
      ers_run_reg  <= 1'b1;
      ers_susp_reg <= 1'b0;
    end else if (sus_fire && !sus_prg_reg && ers_run_reg) begin
      ers_run_reg  <= 1'b0;
      ers_susp_reg <= 1'b1;
    end else if (ers_fin) begin
      ers_run_reg <= 1'b0;
    end else if (ers_run_reg) begin
      ers_cnt_reg <= ers_cnt_reg - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prg_run_reg   <= 1'b0;
      prg_susp_reg  <= 1'b0;
      prg_cnt_reg   <= 32'h0000_0000;
      prog_addr_reg <= `SFES_ADDR_RST;
    end else if (check_go && pend_prog_reg) begin
      prg_run_reg   <= 1'b1;
      prg_cnt_reg   <= PROG_CYC;
      prog_addr_reg <= prot_addr_reg;
    end else if (act_res && prg_susp_reg) begin
      prg_run_reg  <= 1'b1;
      prg_susp_reg <= 1'b0;
    end else if (sus_fire && sus_prg_reg && prg_run_reg) begin
      prg_run_reg  <= 1'b0;
      prg_susp_reg <= 1'b1;
    end else if (prg_fin) begin
      prg_run_reg <= 1'b0;
    end else if (prg_run_reg) begin
      prg_cnt_reg <= prg_cnt_reg - 32'h0000_0001;
    end
  end

  // Start and finish pulses for the array datapath
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      erase_start_reg <= 1'b0;
      prog_start_reg  <= 1'b0;
      op_done_reg     <= 1'b0;
    end else begin
      erase_start_reg <= (check_go && !pend_prog_reg) || act_chip;
      prog_start_reg  <= check_go && pend_prog_reg;
      op_done_reg     <= ers_fin || prg_fin;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_undefined_reg <= 1'b0;
    end else begin
      rd_undefined_reg <= (ers_susp_reg &&
          sfes_same(rd_addr, erase_addr_reg, sfes_mask_of(erase_kind_reg))) ||
          (prg_susp_reg && sfes_same(rd_addr, prog_addr_reg, `SFES_MASK_PAGE));
    end
  end

endmodule

// file: verilog/sfes_link.sv
`timescale 1ns/100ps
`include "sfes_regs.svh"

module sfes_link (
  input  wire logic        nrst,           // Asynchronous reset, active low
  input  wire logic        sck,            // Serial clock from the host
  input  wire logic        cs_n,           // Chip select, active low
  input  wire logic        mosi,           // Serial data in
  output logic [7:0]       opcode_reg,     // First byte of the frame
  output logic [23:0]      addr_reg,       // Bytes two to four
  output logic [2:0]       byte_cnt_reg,   // Whole bytes, saturating
  output logic [2:0]       bit_cnt_reg,    // Bits past the last byte
  output logic             frame_tog_reg   // Flips once per frame
);

  logic       fresh_reg;
  logic [6:0] shift_reg;
  logic [7:0] byte_now;

  assign byte_now = {shift_reg, mosi};

  // Armed by chip select high; the clock stops between frames, so the
  // first edge of the next frame is the only place to restart counting
  always_ff @(posedge sck or posedge cs_n or negedge nrst) begin
    if (!nrst) begin
      fresh_reg <= 1'b1;
    end else if (cs_n) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  // Bit shifter and counters, mode 0 sampling on the rising edge
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      shift_reg    <= 7'h00;
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
    end else if (!cs_n) begin
      if (fresh_reg) begin
        shift_reg    <= {6'h00, mosi};
        bit_cnt_reg  <= 3'h1;
        byte_cnt_reg <= 3'h0;
      end else begin
        shift_reg   <= byte_now[6:0];
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == `SFES_LAST_BIT &&
            byte_cnt_reg != `SFES_BYTE_CNT_MAX) begin
          byte_cnt_reg <= byte_cnt_reg + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      opcode_reg <= `SFES_OP_RST;
      addr_reg   <= `SFES_ADDR_RST;
    end else if (!cs_n && !fresh_reg && bit_cnt_reg == `SFES_LAST_BIT) begin
      case (byte_cnt_reg)
        3'h0:    opcode_reg      <= byte_now;
        3'h1:    addr_reg[23:16] <= byte_now;
        3'h2:    addr_reg[15:8]  <= byte_now;
        3'h3:    addr_reg[7:0]   <= byte_now;
        default: addr_reg        <= addr_reg;
      endcase
    end
  end

  // Frame marker for the core side
  always_ff @(posedge sck or negedge nrst) begin
    if (!nrst) begin
      frame_tog_reg <= 1'b0;
    end else if (!cs_n && fresh_reg) begin
      frame_tog_reg <= ~frame_tog_reg;
    end
  end

endmodule

// file: verilog/sfes_pkg.sv
package sfes_pkg;

  // Size of the region an erase covers
  typedef enum logic [1:0] {
    SFES_KIND_4K,
    SFES_KIND_32K,
    SFES_KIND_64K,
    SFES_KIND_CHIP
  } sfes_kind_t;

  // Protection check sequencing
  typedef enum logic {
    SFES_ST_IDLE,
    SFES_ST_CHECK
  } sfes_state_t;

endpackage

// file: verilog/sfes_regs.svh
`ifndef SFES_REGS_SVH
`define SFES_REGS_SVH

// Serial opcodes
`define SFES_OP_ERASE_4K    8'h20
`define SFES_OP_ERASE_32K   8'h52
`define SFES_OP_ERASE_64K   8'hD8
`define SFES_OP_CHIP_A      8'h60
`define SFES_OP_CHIP_B      8'hC7
`define SFES_OP_SUSPEND     8'h75
`define SFES_OP_RESUME      8'h7A
`define SFES_OP_WREN        8'h06
`define SFES_OP_WRDI        8'h04
`define SFES_OP_PROGRAM     8'h02

// Frame lengths in whole bytes, counter saturates at the maximum
`define SFES_OPCODE_BYTES   3'h1
`define SFES_ADDR_END_BYTES 3'h4
`define SFES_PROG_MIN_BYTES 3'h5
`define SFES_BYTE_CNT_MAX   3'h5
`define SFES_LAST_BIT       3'h7

// Low address bits ignored inside each region
`define SFES_MASK_4K        24'h000FFF
`define SFES_MASK_32K       24'h007FFF
`define SFES_MASK_64K       24'h00FFFF
`define SFES_MASK_PAGE      24'h0000FF
`define SFES_MASK_ALL       24'hFFFFFF

// Reset values
`define SFES_WEL_RST        1'b0
`define SFES_ADDR_RST       24'h000000
`define SFES_OP_RST         8'h00

// Clock rate and suspend latency
`define SFES_CLK_MHZ        40
`define SFES_SUS_LAT_US     20
`define SFES_SUS_LAT_CYC    (`SFES_SUS_LAT_US * `SFES_CLK_MHZ)

`endif
